// file: hdl/icu_pkg.sv
package icu_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_EDGE_SEL = 8'hEE;
   localparam logic [7:0] OFS_EN_HIGH  = 8'hE0;
   localparam logic [7:0] OFS_EN_LOW   = 8'hE1;
   localparam logic [7:0] OFS_REQ_HIGH = 8'hE2;
   localparam logic [7:0] OFS_REQ_LOW  = 8'hE3;
   localparam logic [7:0] OFS_PSW      = 8'hE4;

   localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
   localparam logic [7:0] EN_RESET       = 8'h00;
   localparam logic [7:0] PSW_RESET      = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ------------------------------------------------------------------
   // Fields
   // ------------------------------------------------------------------
   localparam int PSW_MASTER_BIT = 2;
   localparam int PSW_BREAK_BIT  = 4;

   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Flag index, lowest index has the highest priority
   localparam int NUM_SRC     = 15;
   localparam int NUM_EXT     = 4;
   localparam int IDX_EXT     = 0;
   localparam int IDX_RX      = 4;
   localparam int IDX_TX      = 5;
   localparam int IDX_SIO     = 6;
   localparam int IDX_TIMER   = 7;
   localparam int IDX_ADC     = 11;
   localparam int IDX_WDT     = 12;
   localparam int IDX_WT      = 13;
   localparam int IDX_BIT     = 14;
   localparam int HIGH_BITS   = 8;
   localparam logic [3:0] SRC_BREAK = 4'hF;

   // ------------------------------------------------------------------
   // Acceptance timing and vectors
   // ------------------------------------------------------------------
   localparam int         ACCEPT_CYCLES   = 8;
   localparam logic [2:0] STEP_CLR_REQ    = 3'h1;
   localparam logic [2:0] STEP_PUSH_FIRST = 3'h2;
   localparam logic [2:0] STEP_PUSH_LAST  = 3'h4;
   localparam logic [2:0] STEP_VECTOR     = 3'h6;
   localparam logic [2:0] STEP_ENTRY      = 3'(ACCEPT_CYCLES - 1);

   localparam logic [15:0] VEC_TOP         = 16'hFFFE;
   localparam logic [15:0] VEC_TABLE_CALL0 = 16'hFFC0;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       uart_rx_done;
      logic       uart_tx_done;
      logic       sio_done;
      logic [3:0] timer_match;
      logic       adc_done;
      logic       wdt_match;
      logic       wt_match;
      logic       bit_overflow;
   } icu_evt_s;

   typedef struct packed {
      logic        busy;
      logic        clear_master;
      logic        clear_req;
      logic        push;
      logic        sp_dec;
      logic [1:0]  push_sel;
      logic        vec_load;
      logic        entry_exec;
      logic [15:0] vector;
   } icu_cpu_s;

   typedef enum {ST_IDLE, ST_ACCEPT} icu_state_e;

endpackage : icu_pkg

// file: hdl/icu_top.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - fifteen flagged sources, fixed ranked priority
// - external lines select rising, falling or both
// - external flag cleared when vectored to
// - timer flags set on compare match
// - interval timer flag set on overflow
// - converter flag set on conversion end
// - watchdog flags set on timer match
// - serial receive and transmit flags separately
// - sync serial flag set on transfer done
// - accept needs flag, enable and master
// - master enable is status bit two
// - higher priority wins on simultaneous requests
// - hardware polling picks among simultaneous requests
// - request held until accepted or cleared
// - acceptance sequence lasts eight clock cycles
// - clear master, flag, push three, vector, execute
// - non-maskable acceptance blocks following interrupts
// - only PC and status saved by hardware
// - no maskable acceptance while master enable clear
// - break lowest priority, shared vector, break flag
// - edges latched, sampled the following cycle
module icu_top
   import icu_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic [3:0] ext_irq_i,
   input  wire logic [3:0] port_select_i,
   input  wire icu_evt_s   evt_i,
   input  wire logic       instr_done_i,
   input  wire logic       break_i,
   input  wire logic       irq_en_set_i,
   input  wire logic       irq_return_i,
   input  wire logic [7:0] psw_restore_i,
   output icu_cpu_s        cpu_o,
   output logic      [7:0] psw_o,
   output logic      [3:0] accept_src_o
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Fixed scan from the lowest index is the polling order; with no rotation
   // a source that keeps firing can starve everything ranked below it
   function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : first_set

   // Vectors sit two bytes apart below the top of memory
   function automatic logic [15:0] vector_of(input logic [3:0] src);
      logic [15:0] v;
      v = VEC_TOP - {11'h000, src, 1'b0};
      if (src == SRC_BREAK) begin
         v = VEC_TABLE_CALL0;
      end
      return v;
   endfunction : vector_of

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [7:0]         edge_sel;
   logic [NUM_SRC-1:0] enable;
   logic [NUM_SRC-1:0] request;
   logic [NUM_SRC-1:0] set_ev;
   logic [NUM_SRC-1:0] clr_mask;
   logic [NUM_SRC-1:0] wr_keep;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_EXT-1:0] sync1;
   logic [NUM_EXT-1:0] sync2;
   logic [NUM_EXT-1:0] sync3;
   logic [NUM_EXT-1:0] settled;
   logic               break_pend;
   logic               nmi_block;
   logic               take_mask;
   logic               take_break;
   logic [3:0]         sel_src;
   icu_state_e         state;
   logic [2:0]         step;
   logic               in_accept;
   logic               at_clr_master;
   logic               at_clr_req;
   logic               at_push;
   logic               at_vector;
   logic               at_entry;

   wire logic wr_req_hi = wr_i && (addr_i == OFS_REQ_HIGH);
   wire logic wr_req_lo = wr_i && (addr_i == OFS_REQ_LOW);
   wire logic wr_psw    = wr_i && (addr_i == OFS_PSW);
   wire logic wr_edge   = wr_i && (addr_i == OFS_EDGE_SEL);
   wire logic wr_en_hi  = wr_i && (addr_i == OFS_EN_HIGH);
   wire logic wr_en_lo  = wr_i && (addr_i == OFS_EN_LOW);
   wire logic idle      = (state == ST_IDLE);

   // ------------------------------------------------------------------
   // External line synchronisers and edge detect
   // ------------------------------------------------------------------
   generate
      for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
         logic [1:0] mode;
         logic       rise;
         logic       fall;
         assign mode = edge_sel[2*g +: 2];
         assign rise = sync2[g] && sync3[g] && !settled[g];
         assign fall = !sync2[g] && !sync3[g] && settled[g];
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
               sync3[g] <= 1'b0;
            end else begin
               sync1[g] <= ext_irq_i[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
            end
         end
         // A level counts only once the last two stages agree, so a pin
         // glitch shorter than one clock never raises a flag
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               settled[g] <= 1'b0;
            end else if (sync2[g] == sync3[g]) begin
               settled[g] <= sync3[g];
            end
         end
         // Pin is ignored unless software routed it to the interrupt logic
         assign set_ev[IDX_EXT+g] = port_select_i[g] && (
            ((mode == EDGE_RISE || mode == EDGE_BOTH) && rise) ||
            ((mode == EDGE_FALL || mode == EDGE_BOTH) && fall));
      end
   endgenerate

   // ------------------------------------------------------------------
   // Peripheral request events
   // ------------------------------------------------------------------
   // Peripheral events are one-cycle pulses on this clock: no synchroniser
   assign set_ev[IDX_RX]          = evt_i.uart_rx_done;
   assign set_ev[IDX_TX]          = evt_i.uart_tx_done;
   assign set_ev[IDX_SIO]         = evt_i.sio_done;
   assign set_ev[IDX_TIMER +: 4]  = evt_i.timer_match;
   assign set_ev[IDX_ADC]         = evt_i.adc_done;
   assign set_ev[IDX_WDT]         = evt_i.wdt_match;
   assign set_ev[IDX_WT]          = evt_i.wt_match;
   assign set_ev[IDX_BIT]         = evt_i.bit_overflow;

   // ------------------------------------------------------------------
   // Request flags
   // ------------------------------------------------------------------
   always_comb begin
      clr_mask = '0;
      if (at_clr_req && accept_src_o != SRC_BREAK) begin
         clr_mask[accept_src_o] = 1'b1;
      end
      wr_keep = '1;
      if (wr_req_hi) begin
         wr_keep[HIGH_BITS-1:0] = wdata_i;
      end
      if (wr_req_lo) begin
         wr_keep[NUM_SRC-1:HIGH_BITS] = wdata_i[NUM_SRC-HIGH_BITS-1:0];
      end
   end

   // A new event in the clearing cycle survives: set wins. A written zero
   // clears and a one keeps, so software can never forge a request
   generate
      for (genvar s = 0; s < NUM_SRC; s++) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               request[s] <= 1'b0;
            end else if (set_ev[s]) begin
               request[s] <= 1'b1;
            end else if (!wr_keep[s] || clr_mask[s]) begin
               request[s] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Enables and edge selection
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         edge_sel <= EDGE_SEL_RESET;
      end else if (wr_edge) begin
         edge_sel <= wdata_i;
      end
   end

   // Enables gate arbitration only; a masked source still latches its flag
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         enable <= {EN_RESET[NUM_SRC-HIGH_BITS-1:0], EN_RESET};
      end else begin
         if (wr_en_hi) begin
            enable[HIGH_BITS-1:0] <= wdata_i;
         end
         if (wr_en_lo) begin
            enable[NUM_SRC-1:HIGH_BITS] <= wdata_i[NUM_SRC-HIGH_BITS-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------------
   // Only registered flags are looked at, so an edge is sampled a cycle later
   assign pending    = request & enable;
   assign sel_src    = first_set(pending);
   assign take_mask  = idle && instr_done_i && !nmi_block &&
                       psw_o[PSW_MASTER_BIT] && (|pending);
   // Break ignores enables and master flag, and loses to any maskable source
   assign take_break = idle && instr_done_i && !nmi_block &&
                       break_pend && !take_mask;

   // Break stays latched until taken, so one raised during a busy sequence is kept
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         break_pend <= 1'b0;
      end else if (break_i) begin
         break_pend <= 1'b1;
      end else if (take_break) begin
         break_pend <= 1'b0;
      end
   end

   // Held until the service routine returns
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         nmi_block <= 1'b0;
      end else if (take_break) begin
         nmi_block <= 1'b1;
      // A return is the only way out; a core that never returns stays blocked
      end else if (irq_return_i) begin
         nmi_block <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Acceptance sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state        <= ST_IDLE;
         step         <= 3'h0;
         accept_src_o <= 4'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               // Boundaries are ignored while busy; a new request waits for the next
               step <= 3'h0;
               if (take_mask || take_break) begin
                  state        <= ST_ACCEPT;
                  accept_src_o <= take_mask ? sel_src : SRC_BREAK;
               end
            end
            ST_ACCEPT: begin
               step <= step + 3'h1;
               if (step == STEP_ENTRY) begin
                  state <= ST_IDLE;
                  step  <= 3'h0;
               end
            end
            default: begin
               state <= ST_IDLE;
               step  <= 3'h0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Step decode
   // ------------------------------------------------------------------
   // One decode feeds strobes, flag clearing and the status word, so the
   // three can never disagree about which cycle is which
   assign in_accept     = (state == ST_ACCEPT);
   assign at_clr_master = in_accept && (step == 3'h0);
   assign at_clr_req    = in_accept && (step == STEP_CLR_REQ);
   assign at_push       = in_accept && (step >= STEP_PUSH_FIRST) && (step <= STEP_PUSH_LAST);
   assign at_vector     = in_accept && (step == STEP_VECTOR);
   assign at_entry      = in_accept && (step == STEP_ENTRY);

   // Strobes toward the core, one cycle behind the step counter
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cpu_o <= '0;
      end else begin
         cpu_o              <= '0;
         // The vector stands until the next acceptance for the core to fetch
         cpu_o.vector       <= cpu_o.vector;
         cpu_o.busy         <= in_accept;
         cpu_o.clear_master <= at_clr_master;
         cpu_o.clear_req    <= at_clr_req;
         // Only PC high, PC low and status are pushed; the rest is software's job
         if (at_push) begin
            cpu_o.push     <= 1'b1;
            cpu_o.sp_dec   <= 1'b1;
            cpu_o.push_sel <= 2'(step - STEP_PUSH_FIRST);
         end
         if (at_vector) begin
            cpu_o.vec_load <= 1'b1;
            cpu_o.vector   <= vector_of(accept_src_o);
         end
         cpu_o.entry_exec   <= at_entry;
      end
   end

   // ------------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         psw_o <= PSW_RESET;
      // Acceptance outranks a same-cycle write, so software cannot reopen the gate
      end else if (at_clr_master) begin
         psw_o[PSW_MASTER_BIT] <= 1'b0;
         if (accept_src_o == SRC_BREAK) begin
            psw_o[PSW_BREAK_BIT] <= 1'b1;
         end
      end else if (irq_return_i) begin
         psw_o <= psw_restore_i;
      end else if (wr_psw) begin
         psw_o <= wdata_i;
      end else if (irq_en_set_i) begin
         psw_o[PSW_MASTER_BIT] <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_o <= RDATA_UNMAPPED;
      // Reading has no side effects; flags clear only by write or acceptance
      end else if (rd_i) begin
         case (addr_i)
            OFS_EDGE_SEL: rdata_o <= edge_sel;
            OFS_EN_HIGH:  rdata_o <= enable[HIGH_BITS-1:0];
            OFS_EN_LOW:   rdata_o <= {1'b0, enable[NUM_SRC-1:HIGH_BITS]};
            OFS_REQ_HIGH: rdata_o <= request[HIGH_BITS-1:0];
            OFS_REQ_LOW:  rdata_o <= {1'b0, request[NUM_SRC-1:HIGH_BITS]};
            OFS_PSW:      rdata_o <= psw_o;
            default:      rdata_o <= RDATA_UNMAPPED;
         endcase
      end else begin
         rdata_o <= RDATA_UNMAPPED;
      end
   end

endmodule : icu_top

`default_nettype wire

// file: verif/icu_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module icu_monitor
   import icu_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       rd_i,
   input  wire logic [7:0] rdata_o,
   input  wire icu_cpu_s   cpu_o,
   input  wire logic [7:0] psw_o,
   input  wire logic [3:0] accept_src_o
);
   logic [15:0] exp_vec;

   assign exp_vec = (accept_src_o == SRC_BREAK) ? VEC_TABLE_CALL0
                  : VEC_TOP - {11'h000, accept_src_o, 1'b0};

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // ------------------------------------------------------------------
   // Acceptance sequence
   // ------------------------------------------------------------------
   a_busy_eight: assert property (
      $rose(cpu_o.busy) |-> cpu_o.busy [*8] ##1 !cpu_o.busy)
      else $error("busy length wrong");
   a_master_first: assert property (
      $rose(cpu_o.busy) |-> cpu_o.clear_master && !psw_o[PSW_MASTER_BIT])
      else $error("master not cleared first");
   a_req_next: assert property (
      cpu_o.clear_master |=> cpu_o.clear_req && !cpu_o.push)
      else $error("request clear misplaced");
   a_push_three: assert property (
      cpu_o.clear_req |=> (cpu_o.push && cpu_o.sp_dec && cpu_o.push_sel == 2'h0)
      ##1 (cpu_o.push && cpu_o.push_sel == 2'h1) ##1 (cpu_o.push && cpu_o.push_sel == 2'h2)
      ##1 !cpu_o.push)
      else $error("push sequence wrong");
   a_vec_entry: assert property (
      cpu_o.clear_req |-> ##5 cpu_o.vec_load ##1 cpu_o.entry_exec ##1 !cpu_o.busy)
      else $error("vector or entry misplaced");
   a_vec_map: assert property (
      cpu_o.vec_load |-> cpu_o.vector == exp_vec)
      else $error("vector address wrong");
   a_break_flag: assert property (
      cpu_o.clear_master && accept_src_o == SRC_BREAK |-> psw_o[PSW_BREAK_BIT])
      else $error("break flag not set");
   a_master_gate: assert property (
      $rose(cpu_o.busy) && accept_src_o != SRC_BREAK |-> ($past(psw_o, 3) & 8'h04) == 8'h04)
      else $error("accepted while master clear");
   a_rdata_idle: assert property (
      !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its cycle");

   c_break: cover property ($rose(cpu_o.busy) && accept_src_o == SRC_BREAK);
   c_ext: cover property (cpu_o.vec_load && accept_src_o < 4'h4);
   c_lowest: cover property ($rose(cpu_o.busy) && accept_src_o == 4'hE);
endmodule : icu_monitor

bind icu_top icu_monitor icu_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .cpu_o(cpu_o), .psw_o(psw_o), .accept_src_o(accept_src_o));
`default_nettype wire

// file: verif/icu_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module icu_core_model
   import icu_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       step_i,
   input  wire logic       ret_i,
   input  wire icu_cpu_s   cpu_i,
   input  wire logic [7:0] psw_i,
   output logic            instr_done_o,
   output logic            irq_return_o,
   output logic      [7:0] psw_restore_o
);
   // Completion is gated by the registered busy, which lags the sequence, so one can still complete in its second cycle
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         instr_done_o <= 1'b0;
         irq_return_o <= 1'b0;
      end else begin
         instr_done_o <= step_i && !instr_done_o && !cpu_i.busy;
         irq_return_o <= ret_i;
      end
   end

   // Only the status word is kept; working registers are software's job
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         psw_restore_o <= 8'h00;
      end else if (cpu_i.push && cpu_i.push_sel == 2'h2) begin
         psw_restore_o <= psw_i;
      end
   end
endmodule : icu_core_model
`default_nettype wire

// file: verif/icu_bench.sv
`timescale 1ns/1ns
`default_nettype none
module icu_bench
   import icu_pkg::*;
;
   logic clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, sw_break = 1'b0, irq_en = 1'b0;
   logic step = 1'b0, ret = 1'b0, instr_done, irq_ret;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, processor_status_word, psw_rest;
   logic [3:0] ext = 4'h0, port_sel = 4'h0, acc_src, s;
   icu_evt_s   evt = '0;
   icu_cpu_s   cpu;
   logic [14:0] exp;
   logic [10:0] v;
   int seed = 4, mismatches = 0, total_checks = 0, cycles = 0;

   always #25 clk_i = ~clk_i;

   icu_top icu_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_irq_i(ext), .port_select_i(port_sel),
      .evt_i(evt), .instr_done_i(instr_done), .break_i(sw_break), .irq_en_set_i(irq_en),
      .irq_return_i(irq_ret), .psw_restore_i(psw_rest), .cpu_o(cpu), .psw_o(processor_status_word),
      .accept_src_o(acc_src));
   icu_core_model icu_core_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .step_i(step),
      .ret_i(ret), .cpu_i(cpu), .psw_i(processor_status_word), .instr_done_o(instr_done), .irq_return_o(irq_ret),
      .psw_restore_o(psw_rest));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want) begin
         $display("ERROR %0t: got %h expected %h", $time, got, want);
         mismatches++;
      end
   endtask : chk

   function automatic logic [15:0] exp_vec(input logic [3:0] src);
      return (src == SRC_BREAK) ? VEC_TABLE_CALL0 : VEC_TOP - {11'h000, src, 1'b0};
   endfunction : exp_vec

   function automatic logic [3:0] lowest(input logic [14:0] r);
      logic [3:0] k;
      k = 4'h0;
      for (int i = 14; i >= 0; i--) if (r[i]) k = 4'(i);
      return k;
   endfunction : lowest

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wreg

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a; rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask : rdchk

   // Which: 0 enable interrupts, 1 software break, 2 interrupt return
   task automatic pulse(input int which);
      @(posedge clk_i);
      irq_en   <= (which == 0);
      sw_break <= (which == 1);
      ret      <= (which == 2);
      @(posedge clk_i);
      irq_en   <= 1'b0;
      sw_break <= 1'b0;
      ret      <= 1'b0;
   endtask : pulse

   task automatic accept(input logic [3:0] src);
      int n;
      n = 0;
      @(posedge clk_i);
      step <= 1'b1;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (cpu.vec_load !== 1'b1 && n < 40);
      @(posedge clk_i);
      step <= 1'b0;
      chk({12'h000, acc_src}, {12'h000, src});
      chk(cpu.vector, exp_vec(src));
      repeat (3) @(posedge clk_i);
   endtask : accept

   task automatic no_accept();
      logic seen;
      seen = 1'b0;
      @(posedge clk_i);
      step <= 1'b1;
      repeat (12) begin
         @(posedge clk_i);
         #1 seen = seen | cpu.busy;
      end
      @(posedge clk_i);
      step <= 1'b0;
      chk({15'h0000, seen}, 16'h0000);
   endtask : no_accept

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (int a = 0; a < 6; a++) rdchk(8'hE0 + 8'(a == 5 ? 14 : a), 8'h00);
      wreg(8'h55, 8'hFF);
      rdchk(8'h55, 8'h00);
      port_sel <= 4'hB;
      wreg(OFS_EDGE_SEL, {EDGE_BOTH, EDGE_FALL, EDGE_RISE, EDGE_NONE});
      rdchk(OFS_EDGE_SEL, {EDGE_BOTH, EDGE_FALL, EDGE_RISE, EDGE_NONE});
      @(posedge clk_i) ext <= 4'hF;
      repeat (6) @(posedge clk_i);
      rdchk(OFS_REQ_HIGH, 8'h0A);
      wreg(OFS_REQ_HIGH, 8'h00);
      @(posedge clk_i) ext <= 4'h0;
      repeat (6) @(posedge clk_i);
      rdchk(OFS_REQ_HIGH, 8'h08);
      wreg(OFS_REQ_HIGH, 8'h00);
      @(posedge clk_i) ext <= 4'hF;
      v = 11'($random(seed)) | 11'h001;
      @(posedge clk_i) evt <= icu_evt_s'(v);
      @(posedge clk_i) evt <= '0;
      repeat (2) @(posedge clk_i);
      exp[3:0] = 4'hA;
      for (int i = 4; i < 15; i++) exp[i] = v[14-i];
      exp[10:7] = v[7:4];
      rdchk(OFS_REQ_HIGH, exp[7:0]);
      rdchk(OFS_REQ_LOW, {1'b0, exp[14:8]});
      pulse(0);
      no_accept();
      wreg(OFS_EN_HIGH, 8'hFF);
      wreg(OFS_EN_LOW, 8'hFF);
      rdchk(OFS_EN_LOW, 8'h7F);
      while (exp != 15'h0000) begin
         s = lowest(exp);
         pulse(0);
         accept(s);
         chk({8'h00, processor_status_word}, 16'h0000);
         no_accept();
         exp[s] = 1'b0;
         rdchk(OFS_REQ_HIGH, exp[7:0]);
         rdchk(OFS_REQ_LOW, {1'b0, exp[14:8]});
      end
      pulse(1);
      accept(SRC_BREAK);
      chk({8'h00, processor_status_word}, 16'h0010);
      @(posedge clk_i) evt <= icu_evt_s'(11'h001);
      @(posedge clk_i) evt <= '0;
      pulse(0);
      no_accept();
      pulse(2);
      repeat (2) @(posedge clk_i);
      chk({8'h00, processor_status_word}, 16'h0010);
      pulse(0);
      accept(4'hE);
      end_sim();
   end
endmodule : icu_bench
`default_nettype wire
